// ===== dv/oau_mem_model.sv
// Behavioural model of the memory spaces facing the operand unit
`timescale 1ns/100ps

module oau_mem_model (
  input  logic        core_clk,
  input  logic        sys_rst,
  input  logic        sfr_rd,
  input  logic [7:0]  sfr_addr,
  input  logic        code_rd,
  input  logic [15:0] code_addr,
  input  logic        xram_rd,
  input  logic [15:0] xram_addr,
  output logic [7:0]  sfr_rdata,
  output logic [7:0]  code_rdata,
  output logic [7:0]  xram_rdata
);
  // Data stands in the strobe cycle and the next only; a changing pattern
  // elsewhere so a late sample cannot pass by luck
  logic [7:0] junk_reg;
  logic [2:0] hold_reg;

  always_ff @(posedge core_clk) begin
    junk_reg <= sys_rst ? 8'ha5 : junk_reg + 8'h5b;
    hold_reg <= {sfr_rd, code_rd, xram_rd};
  end

  assign sfr_rdata  = (sfr_rd | hold_reg[2]) ? sfr_addr ^ 8'h3c : junk_reg;
  assign code_rdata = (code_rd | hold_reg[1]) ? code_addr[7:0] + code_addr[15:8] : ~junk_reg;
  assign xram_rdata = (xram_rd | hold_reg[0]) ? ~xram_addr[7:0] : junk_reg ^ 8'h0f;
endmodule

// ===== dv/oau_unit_checker.sv
// Assertion checker for the operand addressing and arithmetic unit
`timescale 1ns/100ps

module oau_unit_checker (
  input logic        core_clk,
  input logic        sys_rst,
  input logic        cmd_valid,
  input logic        busy,
  input logic        done,
  input logic        err,
  input logic [7:0]  acc_out,
  input logic [7:0]  aux_out,
  input logic [15:0] data_pointer_16_out,
  input logic [7:0]  sfr_addr,
  input logic        sfr_rd,
  input logic        sfr_wr,
  input logic        code_rd,
  input logic        xram_rd,
  input logic        xram_wr
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // --------------------------------
  // Command steps
  // --------------------------------
  sequence s_take;
    cmd_valid && !busy;
  endsequence
  // Refused commands end one cycle early, with err beside done
  sequence s_finish;
    ##2 (done && err) or ##3 done or ##4 done;
  endsequence

  AST_TAKE_DONE: assert property (s_take |-> s_finish)
    else $error("command not finished in time");
  AST_TAKE_BUSY: assert property (s_take |=> busy ##1 (busy || err))
    else $error("busy not held after take");
  AST_DONE_ONE: assert property (done |-> !busy ##1 !done)
    else $error("done not a single idle pulse");
  AST_ERR_DONE: assert property (err |-> done)
    else $error("err without done");
  AST_ERR_KEEP: assert property (
    err |-> $stable(acc_out) && $stable(aux_out) && $stable(data_pointer_16_out))
    else $error("state changed on refused command");
  AST_SFR_SPACE: assert property ((sfr_rd || sfr_wr) |-> sfr_addr[7])
    else $error("special register access below 80h");
  AST_RD_LAT: assert property ((sfr_rd || code_rd || xram_rd) |-> !done ##2 done)
    else $error("read not completed two cycles after strobe");
  AST_WR_DONE: assert property ((sfr_wr || xram_wr) |-> done && !err)
    else $error("write strobe outside a good done cycle");
  AST_ONE_STROBE: assert property ($onehot0({sfr_rd, sfr_wr, code_rd, xram_rd, xram_wr}))
    else $error("more than one memory strobe");
  AST_DATA_POINTER_16_DONE: assert property ($changed(data_pointer_16_out) |-> done && !err)
    else $error("data pointer moved outside done");
  AST_ACC_DONE: assert property ($changed(acc_out) |-> done)
    else $error("accumulator moved outside done");
endmodule

bind oau_unit oau_unit_checker u_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .busy(busy),
  .done(done), .err(err), .acc_out(acc_out), .aux_out(aux_out), .data_pointer_16_out(data_pointer_16_out),
  .sfr_addr(sfr_addr), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr), .code_rd(code_rd),
  .xram_rd(xram_rd), .xram_wr(xram_wr)
);

// ===== dv/tb_top.sv
// Random and directed bench for the operand addressing and arithmetic unit
`timescale 1ns/100ps

module tb_top
  import oau_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cmd_valid = 1'b0;
  oau_op_t     cmd_op = OAU_OP_ADD;
  oau_mode_t   cmd_mode = OAU_MD_NONE;
  logic [7:0]  cmd_field = 8'h00;
  logic [2:0]  cmd_reg = 3'h0;
  logic [15:0] cmd_word = 16'h0000;
  logic [7:0]  sfr_rdata, code_rdata, xram_rdata, acc_out, aux_out, sp_out, psw_out;
  logic [7:0]  sfr_addr, sfr_wdata, xram_wdata, a, b, v;
  logic [15:0] data_pointer_16_out, code_addr, xram_addr, p;
  logic [8:0]  s;
  logic        busy, done, err, sfr_rd, sfr_wr, code_rd, xram_rd, xram_wr, seen_err;
  logic [31:0] seed = 32'h0000_d096;
  int          mismatches = 0;
  int          num_checks = 0;
  int          i, j, k;

  always #2.5 core_clk = ~core_clk;

  oau_unit DUT (
    .core_clk, .sys_rst, .cmd_valid, .cmd_op, .cmd_mode, .cmd_field, .cmd_reg, .cmd_word,
    .sfr_rdata, .code_rdata, .xram_rdata, .busy, .done, .err, .acc_out, .aux_out,
    .data_pointer_16_out, .sp_out, .psw_out, .sfr_addr, .sfr_wdata, .sfr_rd, .sfr_wr, .code_addr,
    .code_rd, .xram_addr, .xram_wdata, .xram_rd, .xram_wr
  );
  oau_mem_model u_mem (
    .core_clk, .sys_rst, .sfr_rd, .sfr_addr, .code_rd, .code_addr, .xram_rd, .xram_addr,
    .sfr_rdata, .code_rdata, .xram_rdata
  );

  // --------------------------------
  // Helpers
  // --------------------------------
  function automatic logic [7:0] rnd8();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  function automatic logic [7:0] bcd(input int x);
    return {4'(x / 10), 4'(x % 10)};
  endfunction
  function automatic logic [8:0] arith(input int o, input logic [7:0] x, y, input logic c);
    if (o == 0) return {1'b0, x} + {1'b0, y};
    if (o == 1) return {1'b0, x} + {1'b0, y} + 9'(c);
    return {1'b0, x} - {1'b0, y} - 9'(c);
  endfunction

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask

  // One command at a time; drivers move at the falling edge, bounded wait on done
  task automatic run(input oau_op_t o, input oau_mode_t m, input logic [7:0] f,
                     input logic [2:0] r = 3'h0, input logic [15:0] w = 16'h0000);
    int n = 0;
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_op = o;
    cmd_mode = m;
    cmd_field = f;
    cmd_reg = r;
    cmd_word = w;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 9) begin
      @(negedge core_clk);
      n++;
    end
    if (n == 9) chk8("done_wait", 8'h01, 8'h00);
    seen_err = err;
  endtask
  task automatic ldi(input logic [7:0] x);
    run(OAU_OP_LD_A, OAU_MD_IMM, x);
  endtask
  task automatic program_status_word(input logic [7:0] x);
    run(OAU_OP_LD_PSW, OAU_MD_IMM, x);
  endtask
  task automatic tdone(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge core_clk);
    mismatches++;
    end_of_test();
  end

  // --------------------------------
  // Tests
  // --------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    chk8("sp_reset", 8'h07, sp_out);
    chk16("data_pointer_16_reset", 16'h0000, data_pointer_16_out);
    tdone("reset");
    for (i = 0; i < 6; i++) begin
      a = (i == 0) ? 8'hff : rnd8();
      b = (i == 0) ? 8'hff : rnd8();
      ldi(a);
      run(OAU_OP_LD_AUX, OAU_MD_IMM, b);
      run(OAU_OP_MUL, OAU_MD_NONE, 8'h00);
      p = a * b;
      chk8("mul_lo", p[7:0], acc_out);
      chk8("mul_hi", p[15:8], aux_out);
      v = rnd8();
      b = i[0] ? (8'h01 << v[2:0]) : (v | 8'h01);
      ldi(a);
      run(OAU_OP_LD_AUX, OAU_MD_IMM, b);
      run(OAU_OP_DIV, OAU_MD_NONE, 8'h00);
      chk8("quot", a / b, acc_out);
      chk8("rem", i[0] ? (a & (b - 8'h01)) : (a % b), aux_out);
    end
    tdone("mul_div");
    for (i = 0; i < 9; i++) begin
      a = rnd8();
      b = rnd8();
      ldi(b);
      run(OAU_OP_ST_A, OAU_MD_DIRECT, 8'h30);
      ldi(a);
      s = arith(i % 3, a, b, psw_out[7]);
      run(oau_op_t'(i % 3), i[0] ? OAU_MD_DIRECT : OAU_MD_IMM, i[0] ? 8'h30 : b);
      chk8("sum", s[7:0], acc_out);
      chk8("carry", {7'h00, s[8]}, {7'h00, psw_out[7]});
    end
    tdone("arith");
    for (i = 0; i < 4; i++) begin
      j = (i == 0) ? 99 : rnd8() % 100;
      k = (i == 0) ? 99 : rnd8() % 100;
      ldi(bcd(j));
      run(OAU_OP_ADD, OAU_MD_IMM, bcd(k));
      run(OAU_OP_DA, OAU_MD_NONE, 8'h00);
      chk8("bcd", bcd((j + k) % 100), acc_out);
      chk8("bcd_cy", {7'h00, j + k > 99}, {7'h00, psw_out[7]});
    end
    tdone("decimal");
    for (i = 0; i < 4; i++) begin
      v = rnd8();
      program_status_word({3'h0, 2'(i), 3'h0});
      ldi(v);
      run(OAU_OP_ST_A, OAU_MD_REG, 8'h00, 3'(i + 3));
      program_status_word(8'h00);
      run(OAU_OP_LD_A, OAU_MD_DIRECT, 8'(i * 9 + 3));
      chk8("bank_reg", v, acc_out);
    end
    tdone("banks");
    v = rnd8();
    program_status_word(8'h10);
    ldi(8'h50);
    run(OAU_OP_ST_A, OAU_MD_REG, 8'h00, 3'h1);
    ldi(v);
    run(OAU_OP_ST_A, OAU_MD_IND_R, 8'h00, 3'h1);
    run(OAU_OP_ST_A, OAU_MD_DIRECT, 8'h07);
    program_status_word(8'h00);
    run(OAU_OP_INC_BYTE, OAU_MD_DIRECT, 8'h50);
    chk8("acc_kept", v, acc_out);
    run(OAU_OP_LD_A, OAU_MD_DIRECT, 8'h50);
    chk8("ind_ram", v + 8'h01, acc_out);
    run(OAU_OP_LD_A, OAU_MD_IND_SP, 8'h00);
    chk8("ind_sp", v, acc_out);
    run(OAU_OP_DEC_BYTE, OAU_MD_REG, 8'h00, 3'h7);
    run(OAU_OP_LD_SP, OAU_MD_REG, 8'h00, 3'h7);
    chk8("dec_sp", v - 8'h01, sp_out);
    run(OAU_OP_DEC_A, OAU_MD_NONE, 8'h00);
    chk8("dec_a", v - 8'h01, acc_out);
    run(OAU_OP_ST_A, OAU_MD_DIRECT, 8'h00);
    run(OAU_OP_LD_A, OAU_MD_IND_RX, 8'h00, 3'h0);
    chk16("xrx_a", {8'h00, v - 8'h01}, xram_addr);
    chk8("xrx_d", ~(v - 8'h01), acc_out);
    tdone("indirect");
    run(OAU_OP_LD_A, OAU_MD_DIRECT, 8'h90);
    chk8("sfr_rd", 8'h90 ^ 8'h3c, acc_out);
    run(OAU_OP_INC_BYTE, OAU_MD_DIRECT, 8'ha8);
    chk8("sfr_wd", (8'ha8 ^ 8'h3c) + 8'h01, sfr_wdata);
    program_status_word(8'h80);
    run(OAU_OP_BIT_ST, OAU_MD_DIRECT, 8'h0b);
    run(OAU_OP_BIT_ST, OAU_MD_DIRECT, 8'hc1);
    chk8("bit_sfr", 8'hc0, sfr_addr);
    chk8("bit_wd", (8'hc0 ^ 8'h3c) | 8'h02, sfr_wdata);
    run(OAU_OP_LD_A, OAU_MD_DIRECT, 8'h21);
    chk8("bit_ram", 8'h08, acc_out);
    program_status_word(8'h00);
    run(OAU_OP_BIT_LD, OAU_MD_DIRECT, 8'h0b);
    chk8("bit_ld", 8'h80, psw_out & 8'h80);
    tdone("special");
    run(OAU_OP_LD_DATA_POINTER_16, OAU_MD_NONE, 8'h00, 3'h0, 16'h12ff);
    run(OAU_OP_INC_DATA_POINTER_16, OAU_MD_NONE, 8'h00);
    chk16("data_pointer_16_inc", 16'h1300, data_pointer_16_out);
    a = rnd8();
    ldi(a);
    run(OAU_OP_MOVC, OAU_MD_NONE, 8'h00);
    p = 16'h1300 + 16'(a);
    chk16("movc_dp", p, code_addr);
    a = p[7:0] + p[15:8];
    chk8("movc_dat", a, acc_out);
    run(OAU_OP_MOVC, OAU_MD_NONE, 8'h00, 3'h1, 16'hfff0);
    chk16("movc_pc", 16'hfff0 + 16'(a), code_addr);
    run(OAU_OP_LD_A, OAU_MD_IND_DATA_POINTER_16, 8'h00);
    chk16("xram_a", 16'h1300, xram_addr);
    chk8("xram_d", 8'hff, acc_out);
    ldi(8'h5a);
    run(OAU_OP_ST_A, OAU_MD_IND_DATA_POINTER_16, 8'h00);
    chk8("xram_wd", 8'h5a, xram_wdata);
    tdone("pointer");
    v = rnd8();
    ldi(v);
    run(OAU_OP_INC_A, OAU_MD_DIRECT, 8'h30);
    chk8("err_fixed", 8'h01, {7'h00, seen_err});
    run(OAU_OP_MOVC, OAU_MD_IMM, 8'h00);
    chk8("err_movc", 8'h01, {7'h00, seen_err});
    run(OAU_OP_ST_A, OAU_MD_IMM, 8'h30);
    chk8("err_store", 8'h01, {7'h00, seen_err});
    chk8("err_acc", v, acc_out);
    run(OAU_OP_INC_A, OAU_MD_NONE, 8'h00);
    chk8("inc_a", v + 8'h01, acc_out);
    tdone("refusals");
    end_of_test();
  end
endmodule

// ===== rtl/oau_pkg.sv
// Types shared by the operand addressing and arithmetic unit
package oau_pkg;

  typedef enum logic [4:0] {
    OAU_OP_ADD, OAU_OP_ADD_WITH_CARRY_OP, OAU_OP_SUBTRACT_WITH_BORROW_OP,
    OAU_OP_INC_A, OAU_OP_DEC_A, OAU_OP_INC_BYTE, OAU_OP_DEC_BYTE,
    OAU_OP_INC_DATA_POINTER_16, OAU_OP_MUL, OAU_OP_DIV, OAU_OP_DA,
    OAU_OP_LD_A, OAU_OP_ST_A, OAU_OP_LD_AUX, OAU_OP_LD_PSW,
    OAU_OP_LD_SP, OAU_OP_LD_DATA_POINTER_16, OAU_OP_MOVC,
    OAU_OP_BIT_LD, OAU_OP_BIT_ST
  } oau_op_t;

  typedef enum logic [2:0] {
    OAU_MD_NONE, OAU_MD_DIRECT, OAU_MD_IND_R, OAU_MD_IND_RX,
    OAU_MD_IND_SP, OAU_MD_IND_DATA_POINTER_16, OAU_MD_REG, OAU_MD_IMM
  } oau_mode_t;

  typedef enum logic [2:0] {
    OAU_SP_NONE, OAU_SP_IRAM, OAU_SP_SFR, OAU_SP_XRAM, OAU_SP_CODE, OAU_SP_IMM
  } oau_space_t;

  typedef enum logic [2:0] {
    OAU_ST_IDLE, OAU_ST_RESOLVE, OAU_ST_WAIT, OAU_ST_EXEC
  } oau_state_t;

endpackage

// ===== rtl/oau_regs.svh
// Address map, field positions and constants of the operand unit
`ifndef OAU_REGS_SVH
`define OAU_REGS_SVH

// Lowest direct address that selects the special function space
`define OAU_SFR_BASE      8'h80
// Internal RAM byte holding bit addresses 00..07
`define OAU_BIT_RAM_BASE  8'h20
// Internal RAM depth in bytes
`define OAU_IRAM_DEPTH    256
// Stack pointer value after reset
`define OAU_SP_RESET      8'h07

// Status word bit positions
`define OAU_PSW_CY        7
`define OAU_PSW_AC        6
`define OAU_PSW_F0        5
`define OAU_PSW_RS1       4
`define OAU_PSW_RS0       3
`define OAU_PSW_OV        2
`define OAU_PSW_P         0

// Decimal adjust constants
`define OAU_BCD_MAX       4'h9
`define OAU_BCD_ADJ_LO    9'h006
`define OAU_BCD_ADJ_HI    9'h060

`endif

// ===== rtl/oau_unit.sv
// Operand address resolution and arithmetic datapath
// Functional notes
// (RULE1) Special registers only direct, 80h..FFh
// (RULE2) Low nibble 0 or 8 bit-addressable
// (RULE3) Bit addresses 80h..FFh hit those registers
// (RULE4) Bits 00..7F live in RAM 32..47
// (RULE5) Direct: 8-bit field, RAM or specials
// (RULE6) Indirect: address read from named register
// (RULE7) 8-bit pointer: bank R0, R1 or stack
// (RULE8) 16-bit pointer: data pointer only
// (RULE9) Register mode: 3-bit field picks register
// (RULE10) Bank chosen by status bank bits
// (RULE11) Banks at 00h, 08h, 10h, 18h
// (RULE12) Fixed-target ops need no address byte
// (RULE13) Immediate: operand follows the opcode
// (RULE14) Indexed mode: program memory reads only
// (RULE15) Indexed address: accumulator plus 16-bit base
// (RULE16) Byte inc/dec leave accumulator alone
// (RULE17) Data pointer increments as 16 bits
// (RULE18) Multiply: high to aux, low to acc
// (RULE19) Divide: quotient acc, remainder aux
// (RULE20) Power-of-two remainder equals shifted bits
// (RULE21) Decimal adjust after packed decimal add
// (RULE22) Add, carry add, borrow subtract forms
`timescale 1ns/100ps
`include "oau_regs.svh"

module oau_unit
  import oau_pkg::*;
(
  input  logic              core_clk,
  input  logic              sys_rst,
  input  logic              cmd_valid,
  input  oau_op_t           cmd_op,
  input  oau_mode_t         cmd_mode,
  input  logic [7:0]        cmd_field,
  input  logic [2:0]        cmd_reg,
  input  logic [15:0]       cmd_word,
  input  logic [7:0]        sfr_rdata,
  input  logic [7:0]        code_rdata,
  input  logic [7:0]        xram_rdata,
  output logic              busy,
  output logic              done,
  output logic              err,
  output logic [7:0]        acc_out,
  output logic [7:0]        aux_out,
  output logic [15:0]       data_pointer_16_out,
  output logic [7:0]        sp_out,
  output logic [7:0]        psw_out,
  output logic [7:0]        sfr_addr,
  output logic [7:0]        sfr_wdata,
  output logic              sfr_rd,
  output logic              sfr_wr,
  output logic [15:0]       code_addr,
  output logic              code_rd,
  output logic [15:0]       xram_addr,
  output logic [7:0]        xram_wdata,
  output logic              xram_rd,
  output logic              xram_wr
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    oau_state_t st;
    oau_op_t    op;
    oau_mode_t  mode;
    oau_space_t space;
    logic [7:0]  field;
    logic [2:0]  rsel;
    logic [15:0] word, ea;
    logic [7:0]  opnd, acc, aux;
    logic [15:0] data_pointer_16;
    logic [7:0]  sp;
    logic        cy, ac, f0, ov;
    logic [1:0]  rs;
    logic        par, busy, done, err;
    logic [7:0]  sfr_addr, sfr_wdata;
    logic        sfr_rd, sfr_wr;
    logic [15:0] code_addr;
    logic        code_rd;
    logic [15:0] xram_addr;
    logic [7:0]  xram_wdata;
    logic        xram_rd, xram_wr;
    logic [`OAU_IRAM_DEPTH-1:0][7:0] ram;
  } oau_state_s_t;

  oau_state_s_t r_reg;
  oau_state_s_t r_next;
  logic [7:0]  ptr, wval;
  logic [15:0] ea, prod;
  oau_space_t  space;
  logic        bad, cin, wr_loc;
  logic [8:0]  sum9, bcd;
  logic [4:0]  lo5;

  // ----------------------------------------------------------------
  // Operation classes
  // ----------------------------------------------------------------
  function automatic logic op_writes(input oau_op_t op);
    op_writes = (op == OAU_OP_INC_BYTE) || (op == OAU_OP_DEC_BYTE) ||
                (op == OAU_OP_ST_A) || (op == OAU_OP_BIT_ST);
  endfunction
  function automatic logic op_fixed(input oau_op_t op);
    op_fixed = (op == OAU_OP_INC_A) || (op == OAU_OP_DEC_A) ||
               (op == OAU_OP_INC_DATA_POINTER_16) || (op == OAU_OP_MUL) ||
               (op == OAU_OP_DIV) || (op == OAU_OP_DA) || (op == OAU_OP_LD_DATA_POINTER_16);
  endfunction
  function automatic logic op_bit(input oau_op_t op);
    op_bit = (op == OAU_OP_BIT_LD) || (op == OAU_OP_BIT_ST);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    ptr    = 8'h00;
    ea     = 16'h0000;
    space  = OAU_SP_NONE;
    bad    = 1'b0;
    cin    = 1'b0;
    sum9   = 9'h000;
    lo5    = 5'h00;
    prod   = 16'h0000;
    bcd    = 9'h000;
    wval   = 8'h00;
    wr_loc = 1'b0;
    r_next.done    = 1'b0;
    r_next.err     = 1'b0;
    r_next.sfr_rd  = 1'b0;
    r_next.sfr_wr  = 1'b0;
    r_next.code_rd = 1'b0;
    r_next.xram_rd = 1'b0;
    r_next.xram_wr = 1'b0;
    case (r_reg.st)
      OAU_ST_IDLE: begin
        if (cmd_valid) begin
          r_next.op    = cmd_op;
          r_next.mode  = cmd_mode;
          r_next.field = cmd_field;
          r_next.rsel  = cmd_reg;
          r_next.word  = cmd_word;
          r_next.st    = OAU_ST_RESOLVE;
        end
      end
      OAU_ST_RESOLVE: begin
        if (op_bit(r_reg.op)) begin
          // Bit mode reuses the direct field as a bit address
          if (r_reg.field < `OAU_SFR_BASE) begin
            space = OAU_SP_IRAM;
            ea = {8'h00, `OAU_BIT_RAM_BASE + {4'h0, r_reg.field[6:3]}}; // RULE4
          end else begin
            space = OAU_SP_SFR;
            ea = {8'h00, r_reg.field[7:3], 3'h0}; // RULE2 RULE3
          end
          bad = (r_reg.mode != OAU_MD_DIRECT);
        end else if (r_reg.op == OAU_OP_MOVC) begin
          // Base from program counter when rsel[0] set, else data pointer
          space = OAU_SP_CODE; // RULE14
          ea = (r_reg.rsel[0] ? r_reg.word : r_reg.data_pointer_16) + {8'h00, r_reg.acc}; // RULE15
          bad = (r_reg.mode != OAU_MD_NONE);
        end else begin
          case (r_reg.mode)
            OAU_MD_DIRECT: begin
              ea = {8'h00, r_reg.field}; // RULE5
              space = (r_reg.field < `OAU_SFR_BASE) ? OAU_SP_IRAM : OAU_SP_SFR; // RULE1
            end
            OAU_MD_IND_R, OAU_MD_IND_RX: begin
              ptr = r_reg.ram[{3'h0, r_reg.rs, 2'h0, r_reg.rsel[0]}]; // RULE6 RULE7
              ea = {8'h00, ptr};
              // Indirect never reaches the special space
              space = (r_reg.mode == OAU_MD_IND_R) ? OAU_SP_IRAM : OAU_SP_XRAM;
            end
            OAU_MD_IND_SP: begin
              ea = {8'h00, r_reg.sp}; // RULE7
              space = OAU_SP_IRAM;
            end
            OAU_MD_IND_DATA_POINTER_16: begin
              ea = r_reg.data_pointer_16; // RULE8
              space = OAU_SP_XRAM;
            end
            OAU_MD_REG: begin
              ea = {8'h00, 3'h0, r_reg.rs, r_reg.rsel}; // RULE9 RULE10 RULE11
              space = OAU_SP_IRAM;
            end
            OAU_MD_IMM: begin
              space = OAU_SP_IMM; // RULE13
            end
            default: begin
              space = OAU_SP_NONE; // RULE12
            end
          endcase
          bad = op_fixed(r_reg.op) ? (space != OAU_SP_NONE) : (space == OAU_SP_NONE);
          if (op_writes(r_reg.op) && (space == OAU_SP_IMM)) begin
            bad = 1'b1;
          end
        end
        r_next.ea    = ea;
        r_next.space = space;
        r_next.st    = OAU_ST_EXEC;
        if (bad) begin
          r_next.err  = 1'b1;
          r_next.done = 1'b1;
          r_next.st   = OAU_ST_IDLE;
        end else if (r_reg.op == OAU_OP_ST_A) begin
          // Skip the read: special registers may react to reads
          r_next.st = OAU_ST_EXEC;
        end else if (space == OAU_SP_IRAM) begin
          r_next.opnd = r_reg.ram[ea[7:0]];
        end else if (space == OAU_SP_IMM) begin
          r_next.opnd = r_reg.field;
        end else if (space == OAU_SP_SFR) begin
          r_next.sfr_addr = ea[7:0];
          r_next.sfr_rd   = 1'b1;
          r_next.st       = OAU_ST_WAIT;
        end else if (space == OAU_SP_XRAM) begin
          r_next.xram_addr = ea;
          r_next.xram_rd   = 1'b1;
          r_next.st        = OAU_ST_WAIT;
        end else if (space == OAU_SP_CODE) begin
          r_next.code_addr = ea;
          r_next.code_rd   = 1'b1;
          r_next.st        = OAU_ST_WAIT;
        end
      end
      OAU_ST_WAIT: begin
        r_next.opnd = (r_reg.space == OAU_SP_SFR)  ? sfr_rdata  :
                      (r_reg.space == OAU_SP_XRAM) ? xram_rdata : code_rdata;
        r_next.st   = OAU_ST_EXEC;
      end
      OAU_ST_EXEC: begin
        r_next.st   = OAU_ST_IDLE;
        r_next.done = 1'b1;
        case (r_reg.op)
          OAU_OP_ADD, OAU_OP_ADD_WITH_CARRY_OP: begin
            cin  = (r_reg.op == OAU_OP_ADD_WITH_CARRY_OP) ? r_reg.cy : 1'b0;
            sum9 = {1'h0, r_reg.acc} + {1'h0, r_reg.opnd} + {8'h00, cin}; // RULE22
            lo5  = {1'h0, r_reg.acc[3:0]} + {1'h0, r_reg.opnd[3:0]} + {4'h0, cin};
            r_next.acc = sum9[7:0];
            r_next.cy  = sum9[8];
            r_next.ac  = lo5[4];
            r_next.ov  = (r_reg.acc[7] == r_reg.opnd[7]) && (sum9[7] != r_reg.acc[7]);
          end
          OAU_OP_SUBTRACT_WITH_BORROW_OP: begin
            sum9 = {1'h0, r_reg.acc} - {1'h0, r_reg.opnd} - {8'h00, r_reg.cy}; // RULE22
            lo5  = {1'h0, r_reg.acc[3:0]} - {1'h0, r_reg.opnd[3:0]} - {4'h0, r_reg.cy};
            r_next.acc = sum9[7:0];
            r_next.cy  = sum9[8];
            r_next.ac  = lo5[4];
            r_next.ov  = (r_reg.acc[7] != r_reg.opnd[7]) && (sum9[7] != r_reg.acc[7]);
          end
          OAU_OP_INC_A: r_next.acc = r_reg.acc + 8'h01;
          OAU_OP_DEC_A: r_next.acc = r_reg.acc - 8'h01;
          OAU_OP_INC_BYTE, OAU_OP_DEC_BYTE: begin
            wval   = (r_reg.op == OAU_OP_INC_BYTE) ? r_reg.opnd + 8'h01 // RULE16
                                                   : r_reg.opnd - 8'h01;
            wr_loc = 1'b1;
          end
          OAU_OP_INC_DATA_POINTER_16: r_next.data_pointer_16 = r_reg.data_pointer_16 + 16'h0001; // RULE17
          OAU_OP_MUL: begin
            prod = {8'h00, r_reg.acc} * {8'h00, r_reg.aux};
            r_next.aux = prod[15:8]; // RULE18
            r_next.acc = prod[7:0];
            r_next.cy  = 1'b0;
            r_next.ov  = (prod[15:8] != 8'h00);
          end
          OAU_OP_DIV: begin
            r_next.cy = 1'b0;
            // Divide by zero keeps both operands and flags overflow
            r_next.ov = (r_reg.aux == 8'h00);
            if (r_reg.aux != 8'h00) begin
              r_next.acc = r_reg.acc / r_reg.aux; // RULE19
              r_next.aux = r_reg.acc % r_reg.aux; // RULE20
            end
          end
          OAU_OP_DA: begin
            // Valid only after adding two packed decimal bytes
            bcd = {1'h0, r_reg.acc};
            if ((bcd[3:0] > `OAU_BCD_MAX) || r_reg.ac) begin
              bcd = bcd + `OAU_BCD_ADJ_LO; // RULE21
            end
            if (bcd[8] || r_reg.cy || (bcd[7:4] > `OAU_BCD_MAX)) begin
              bcd = {1'h0, bcd[7:0]} + `OAU_BCD_ADJ_HI; // RULE21
              r_next.cy = 1'b1;
            end
            r_next.acc = bcd[7:0];
          end
          OAU_OP_LD_A, OAU_OP_MOVC: r_next.acc = r_reg.opnd;
          OAU_OP_LD_AUX: r_next.aux = r_reg.opnd;
          OAU_OP_LD_SP: r_next.sp = r_reg.opnd;
          OAU_OP_LD_DATA_POINTER_16: r_next.data_pointer_16 = r_reg.word;
          OAU_OP_LD_PSW: begin
            r_next.cy = r_reg.opnd[`OAU_PSW_CY];
            r_next.ac = r_reg.opnd[`OAU_PSW_AC];
            r_next.f0 = r_reg.opnd[`OAU_PSW_F0];
            r_next.rs = {r_reg.opnd[`OAU_PSW_RS1], r_reg.opnd[`OAU_PSW_RS0]}; // RULE10
            r_next.ov = r_reg.opnd[`OAU_PSW_OV];
          end
          OAU_OP_ST_A: begin
            wval   = r_reg.acc;
            wr_loc = 1'b1;
          end
          OAU_OP_BIT_LD: r_next.cy = r_reg.opnd[r_reg.field[2:0]]; // RULE2
          OAU_OP_BIT_ST: begin
            wval = r_reg.opnd;
            wval[r_reg.field[2:0]] = r_reg.cy; // RULE3 RULE4
            wr_loc = 1'b1;
          end
          default: r_next.err = 1'b1;
        endcase
        if (wr_loc) begin
          if (r_reg.space == OAU_SP_IRAM) begin
            r_next.ram[r_reg.ea[7:0]] = wval;
          end else if (r_reg.space == OAU_SP_SFR) begin
            r_next.sfr_addr  = r_reg.ea[7:0];
            r_next.sfr_wdata = wval;
            r_next.sfr_wr    = 1'b1;
          end else if (r_reg.space == OAU_SP_XRAM) begin
            r_next.xram_addr  = r_reg.ea;
            r_next.xram_wdata = wval;
            r_next.xram_wr    = 1'b1;
          end
        end
      end
      default: r_next.st = OAU_ST_IDLE;
    endcase
    // Set bit when the accumulator holds an odd number of ones
    r_next.par  = ^r_next.acc;
    r_next.busy = (r_next.st != OAU_ST_IDLE);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      r_reg    <= '0;
      r_reg.sp <= `OAU_SP_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  assign busy       = r_reg.busy;
  assign done       = r_reg.done;
  assign err        = r_reg.err;
  assign acc_out    = r_reg.acc;
  assign aux_out    = r_reg.aux;
  assign data_pointer_16_out   = r_reg.data_pointer_16;
  assign sp_out     = r_reg.sp;
  assign psw_out    = {r_reg.cy, r_reg.ac, r_reg.f0, r_reg.rs, r_reg.ov, 1'b0, r_reg.par};
  assign sfr_addr   = r_reg.sfr_addr;
  assign sfr_wdata  = r_reg.sfr_wdata;
  assign sfr_rd     = r_reg.sfr_rd;
  assign sfr_wr     = r_reg.sfr_wr;
  assign code_addr  = r_reg.code_addr;
  assign code_rd    = r_reg.code_rd;
  assign xram_addr  = r_reg.xram_addr;
  assign xram_wdata = r_reg.xram_wdata;
  assign xram_rd    = r_reg.xram_rd;
  assign xram_wr    = r_reg.xram_wr;

endmodule
